// ==== hw/cisp_byte_reg.sv ====
// Loadable 8-bit register used for Y, the stack pointer and the program counter halves.
`include "cisp_params.svh"
module cisp_byte_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input  wire logic       clk_sys_in,
	input  wire logic       srst_in,
	input  wire logic       load_in,
	input  wire logic [7:0] data_in,
	output logic      [7:0] value_out
);
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			value_out <= RESET_VALUE;
		end else if (load_in) begin
			value_out <= data_in;
		end
	end
endmodule : cisp_byte_reg

// ==== hw/cisp_params.svh ====
// Constants for the index, stack and program counter register block.
`ifndef CISP_PARAMS_SVH
`define CISP_PARAMS_SVH
`define CISP_Y_RESET       8'h00
`define CISP_SP_RESET      8'hFF
`define CISP_PC_RESET      16'h0000
`define CISP_STACK_PAGE0   8'h00
`define CISP_STACK_PAGE1   8'h01
`define CISP_MODE_ADDR     16'h003B
`define CISP_MODE_STACK_BIT 2
`define CISP_MODE_RESET    8'h00
`endif

// ==== hw/cisp_pkg.sv ====
// Types shared by the index, stack and program counter register block.
package cisp_pkg;
	typedef enum logic [2:0] {
		CISP_OP_NONE      = 3'b000,
		CISP_OP_PUSH_ACC  = 3'b001,
		CISP_OP_PUSH_STAT = 3'b010,
		CISP_OP_PULL_ACC  = 3'b011,
		CISP_OP_PULL_STAT = 3'b100
	} cisp_op_t;
	typedef enum logic [1:0] {
		CISP_ST_IDLE = 2'b00,
		CISP_ST_READ = 2'b01
	} cisp_state_t;
endpackage : cisp_pkg

// ==== hw/cisp_regs.sv ====
// Index register Y, stack pointer with stack addressing, program counter and push/pull sequencing.
// Functional notes
// - Y is an 8-bit register whose value is added to an operand to form an effective address.
// - The stack pointer is an 8-bit register pointing into the stack area used by calls and interrupts.
// - The low byte of each stack address is the current stack pointer for a push and the stack pointer plus one for a pull.
// - The stack address high byte is 0x00 with the page bit clear and 0x01 with it set.
// - The program counter is 16 bits in two separately loadable bytes holding the next fetch address.
// - Separate operations push the accumulator and push the status register.
// - Separate operations pull the accumulator and pull the status register.
// - Only the fixed register set is saved automatically; anything else is saved by program.
// - The stack page bit lives in the processor mode register at its fixed special function address.
`include "cisp_params.svh"
module cisp_regs (
	input  wire logic              clk_sys_in,
	input  wire logic              srst_in,
	input  wire logic              y_load_in,
	input  wire logic [7:0]        y_data_in,
	input  wire logic [7:0]        operand_in,
	input  wire logic              sp_load_in,
	input  wire logic [7:0]        sp_data_in,
	input  wire logic              program_counter_high_load_in,
	input  wire logic              program_counter_low_load_in,
	input  wire logic [7:0]        pc_data_in,
	input  wire logic              pc_inc_in,
	input  wire logic              sfr_we_in,
	input  wire logic [15:0]       sfr_addr_in,
	input  wire logic [7:0]        sfr_wdata_in,
	input  wire cisp_pkg::cisp_op_t stack_op_in,
	input  wire logic [7:0]        acc_in,
	input  wire logic [7:0]        status_in,
	input  wire logic [7:0]        mem_rdata_in,
	output logic [7:0]             y_out,
	output logic [15:0]            y_eff_addr_out,
	output logic [7:0]             sp_out,
	output logic [15:0]            program_counter_out,
	output logic [7:0]             processor_mode_register_out,
	output logic [15:0]            mem_addr_out,
	output logic                   mem_we_out,
	output logic                   mem_re_out,
	output logic [7:0]             mem_wdata_out,
	output logic                   acc_load_out,
	output logic                   status_load_out,
	output logic [7:0]             pull_data_out,
	output logic                   busy_out
);
	import cisp_pkg::*;

	// The counter reset is split per byte so each half register gets exactly eight bits.
	localparam logic [15:0] PC_RESET = `CISP_PC_RESET;

	logic [7:0]   y_value;
	logic [7:0]   sp;
	logic [7:0]   program_counter_high;
	logic [7:0]   program_counter_low;
	logic [7:0]   mode_reg;
	cisp_state_t  state;
	cisp_op_t     pending_op;
	logic [15:0]  pc_next_inc;

	wire          stack_page_bit = mode_reg[`CISP_MODE_STACK_BIT];
	wire [7:0]    stack_high     = stack_page_bit ? `CISP_STACK_PAGE1 : `CISP_STACK_PAGE0;
	wire          idle           = (state == CISP_ST_IDLE);
	wire          is_push        = idle && (stack_op_in == CISP_OP_PUSH_ACC || stack_op_in == CISP_OP_PUSH_STAT);
	wire          is_pull        = idle && (stack_op_in == CISP_OP_PULL_ACC || stack_op_in == CISP_OP_PULL_STAT);
	wire [7:0]    sp_dec         = sp - 8'h01;
	wire [7:0]    sp_inc         = sp + 8'h01;
	wire [7:0]    push_data      = (stack_op_in == CISP_OP_PUSH_STAT) ? status_in : acc_in;
	wire          mode_hit       = sfr_we_in && (sfr_addr_in == `CISP_MODE_ADDR);
	wire          sp_wr          = sp_load_in || is_push || is_pull;
	wire [7:0]    next_sp        = sp_load_in ? sp_data_in : (is_push ? sp_dec : sp_inc);
	wire [15:0]   next_pc_inc    = {program_counter_high, program_counter_low} + 16'h0001;
	wire          pc_high_wr     = program_counter_high_load_in || pc_inc_in;
	wire          pc_low_wr      = program_counter_low_load_in || pc_inc_in;
	wire [7:0]    next_pc_high   = program_counter_high_load_in ? pc_data_in : next_pc_inc[15:8];
	wire [7:0]    next_pc_low    = program_counter_low_load_in ? pc_data_in : next_pc_inc[7:0];

	assign pc_next_inc = next_pc_inc;

	cisp_byte_reg #(.RESET_VALUE(`CISP_Y_RESET)) u_y (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.load_in    (y_load_in),
		.data_in    (y_data_in),
		.value_out  (y_value)
	);
	cisp_byte_reg #(.RESET_VALUE(`CISP_SP_RESET)) u_sp (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.load_in    (sp_wr),
		.data_in    (next_sp),
		.value_out  (sp)
	);
	cisp_byte_reg #(.RESET_VALUE(PC_RESET[15:8])) u_pc_high (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.load_in    (pc_high_wr),
		.data_in    (next_pc_high),
		.value_out  (program_counter_high)
	);
	cisp_byte_reg #(.RESET_VALUE(PC_RESET[7:0])) u_pc_low (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.load_in    (pc_low_wr),
		.data_in    (next_pc_low),
		.value_out  (program_counter_low)
	);
	cisp_byte_reg #(.RESET_VALUE(`CISP_MODE_RESET)) u_mode (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.load_in    (mode_hit),
		.data_in    (sfr_wdata_in),
		.value_out  (mode_reg)
	);

	// Pull takes two cycles: the pointer moves first so the read uses the incremented address.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state      <= CISP_ST_IDLE;
			pending_op <= CISP_OP_NONE;
		end else begin
			case (state)
				CISP_ST_IDLE: begin
					if (is_pull) begin
						state      <= CISP_ST_READ;
						pending_op <= stack_op_in;
					end
				end
				CISP_ST_READ: begin
					state <= CISP_ST_IDLE;
				end
				default: begin
					state <= CISP_ST_IDLE;
				end
			endcase
		end
	end

	// Only Y, pointer, counter, mode and the pushed or pulled byte are held here; the core saves others by program.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			y_out                       <= `CISP_Y_RESET;
			y_eff_addr_out              <= 16'h0000;
			sp_out                      <= `CISP_SP_RESET;
			program_counter_out         <= `CISP_PC_RESET;
			processor_mode_register_out <= `CISP_MODE_RESET;
			mem_addr_out                <= 16'h0000;
			mem_we_out                  <= 1'b0;
			mem_re_out                  <= 1'b0;
			mem_wdata_out               <= 8'h00;
			acc_load_out                <= 1'b0;
			status_load_out             <= 1'b0;
			pull_data_out               <= 8'h00;
			busy_out                    <= 1'b0;
		end else begin
			y_out                       <= y_value;
			y_eff_addr_out              <= {8'h00, operand_in} + {8'h00, y_value};
			sp_out                      <= next_sp_view(sp_wr, next_sp, sp);
			program_counter_out         <= {pc_high_wr ? next_pc_high : program_counter_high,
				pc_low_wr ? next_pc_low : program_counter_low};
			processor_mode_register_out <= mode_hit ? sfr_wdata_in : mode_reg;
			mem_we_out                  <= is_push;
			mem_re_out                  <= is_pull;
			mem_wdata_out               <= push_data;
			if (is_push) begin
				mem_addr_out <= {stack_high, sp};
			end else if (is_pull) begin
				mem_addr_out <= {stack_high, sp_inc};
			end
			acc_load_out    <= (state == CISP_ST_READ) && (pending_op == CISP_OP_PULL_ACC);
			status_load_out <= (state == CISP_ST_READ) && (pending_op == CISP_OP_PULL_STAT);
			if (state == CISP_ST_READ) begin
				pull_data_out <= mem_rdata_in;
			end
			busy_out <= is_pull;
		end
	end

	function automatic logic [7:0] next_sp_view(input logic wr, input logic [7:0] nv, input logic [7:0] cv);
		next_sp_view = wr ? nv : cv;
	endfunction : next_sp_view

	property p_push_addr;
		@(posedge clk_sys_in) disable iff (srst_in)
		is_push |=> mem_we_out && mem_addr_out == {$past(stack_high), $past(sp)};
	endproperty
	a_push_addr: assert property (p_push_addr) else $error("Push address wrong.");

	property p_page;
		@(posedge clk_sys_in) disable iff (srst_in)
		(is_push || is_pull) |=> mem_addr_out[15:8] == ($past(stack_page_bit) ? 8'h01 : 8'h00);
	endproperty
	a_page: assert property (p_page) else $error("Stack page byte wrong.");

	property p_push_dec;
		@(posedge clk_sys_in) disable iff (srst_in)
		(is_push && !sp_load_in) |=> sp == $past(sp) - 8'h01;
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("Push did not decrement.");

	property p_pull_inc;
		@(posedge clk_sys_in) disable iff (srst_in)
		(is_pull && !sp_load_in) |=> sp == $past(sp) + 8'h01 && mem_addr_out[7:0] == sp;
	endproperty
	a_pull_inc: assert property (p_pull_inc) else $error("Pull did not increment before read.");

	property p_pull_acc;
		@(posedge clk_sys_in) disable iff (srst_in)
		(is_pull && stack_op_in == CISP_OP_PULL_ACC) |=> ##1 acc_load_out && !status_load_out;
	endproperty
	a_pull_acc: assert property (p_pull_acc) else $error("Accumulator pull not delivered.");

	property p_push_stat;
		@(posedge clk_sys_in) disable iff (srst_in)
		(is_push && stack_op_in == CISP_OP_PUSH_STAT) |=> mem_wdata_out == $past(status_in);
	endproperty
	a_push_stat: assert property (p_push_stat) else $error("Status push data wrong.");

	property p_y_eff;
		@(posedge clk_sys_in) disable iff (srst_in)
		1'b1 |=> y_eff_addr_out == {8'h00, $past(operand_in)} + {8'h00, $past(y_value)};
	endproperty
	a_y_eff: assert property (p_y_eff) else $error("Effective address wrong.");

	property p_pc_inc;
		@(posedge clk_sys_in) disable iff (srst_in)
		(pc_inc_in && !program_counter_high_load_in && !program_counter_low_load_in) |=>
			program_counter_out == $past(pc_next_inc);
	endproperty
	a_pc_inc: assert property (p_pc_inc) else $error("Counter increment wrong.");

	property p_mode;
		@(posedge clk_sys_in) disable iff (srst_in)
		mode_hit |=> stack_page_bit == $past(sfr_wdata_in[`CISP_MODE_STACK_BIT]);
	endproperty
	a_mode: assert property (p_mode) else $error("Mode register write lost.");

	c_push: cover property (@(posedge clk_sys_in) disable iff (srst_in) is_push);
	c_pull: cover property (@(posedge clk_sys_in) disable iff (srst_in) is_pull ##2 status_load_out);
	c_page1: cover property (@(posedge clk_sys_in) disable iff (srst_in) is_push && stack_page_bit);
endmodule : cisp_regs

// ==== tb/cisp_mem_model.sv ====
// Behavioural on-chip memory that holds the stack for the register block.
module cisp_mem_model (
	input  wire logic        clk_sys_in,
	input  wire logic [15:0] addr_in,
	input  wire logic        we_in,
	input  wire logic        re_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [7:0]  rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:511];
	logic [7:0] last;
	initial last = 8'h00;
	always @(posedge clk_sys_in) begin
		if (we_in) mem[addr_in[8:0]] <= wdata_in;
		if (re_in) last <= mem[addr_in[8:0]];
	end
	// Read data is only valid during a read strobe; otherwise it returns the inverse of the last read byte so stale data cannot pass.
	assign rdata_out = re_in ? mem[addr_in[8:0]] : ~last;
endmodule : cisp_mem_model

// ==== tb/cisp_regs_tb.sv ====
// Self-checking testbench for the index, stack and program counter register block.
module cisp_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cisp_pkg::*;
	logic clk = 0, srst = 1, y_load = 0, sp_load = 0, hi_load = 0, lo_load = 0, pc_inc = 0, sfr_we = 0;
	logic [7:0] y_data = 8'h00, operand = 8'h00, sp_data = 8'h00, pc_data = 8'h00, sfr_wdata = 8'h00;
	logic [7:0] acc = 8'h00, status = 8'h00, rdata, y, sp, mode, wdata, pdata;
	logic [15:0] sfr_addr = 16'h0000, y_eff, pc, maddr;
	logic we, re, acc_ld, stat_ld, busy;
	cisp_op_t stack_op = CISP_OP_NONE;
	int n_errors = 0, total_checks = 0;
	cisp_regs u_dut (.clk_sys_in(clk), .srst_in(srst), .y_load_in(y_load), .y_data_in(y_data),
		.operand_in(operand), .sp_load_in(sp_load), .sp_data_in(sp_data), .program_counter_high_load_in(hi_load),
		.program_counter_low_load_in(lo_load), .pc_data_in(pc_data), .pc_inc_in(pc_inc), .sfr_we_in(sfr_we),
		.sfr_addr_in(sfr_addr), .sfr_wdata_in(sfr_wdata), .stack_op_in(stack_op), .acc_in(acc),
		.status_in(status), .mem_rdata_in(rdata), .y_out(y), .y_eff_addr_out(y_eff), .sp_out(sp),
		.program_counter_out(pc), .processor_mode_register_out(mode), .mem_addr_out(maddr),
		.mem_we_out(we), .mem_re_out(re), .mem_wdata_out(wdata), .acc_load_out(acc_ld),
		.status_load_out(stat_ld), .pull_data_out(pdata), .busy_out(busy));
	cisp_mem_model u_mem (.clk_sys_in(clk), .addr_in(maddr), .we_in(we), .re_in(re), .wdata_in(wdata),
		.rdata_out(rdata));
	initial begin
		forever #25 clk = ~clk;
	end
	// Wide enough for the longest packed comparison so no field is cut off silently.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Sets the request at an edge, then waits so the caller sees what that same edge made of the previous request.
	task automatic step(input cisp_op_t op, input logic [7:0] d);
		@(posedge clk);
		stack_op <= op;
		acc <= d;
		status <= ~d;
		#1;
	endtask : step
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic t_reset;
		chk("y", {8'h00, y}, 16'h0000);
		chk("sp", {8'h00, sp}, 16'h00FF);
		chk("pc", pc, 16'h0000);
		chk("mode", {8'h00, mode}, 16'h0000);
		chk("strobes", {we, re, busy, acc_ld, stat_ld}, 5'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_index_pc;
		@(posedge clk) {y_load, y_data, operand, hi_load, pc_data} <= {1'b1, 8'hF0, 8'h20, 1'b1, 8'h12};
		@(posedge clk) {y_load, hi_load, lo_load, pc_data} <= {1'b0, 1'b0, 1'b1, 8'hFF};
		@(posedge clk) {lo_load, pc_inc} <= 2'b01;
		#1 chk("pc bytes", pc, 16'h12FF);
		@(posedge clk) pc_inc <= 1'b0;
		#1 chk("y eff", y_eff, 16'h0110);
		chk("y value", {8'h00, y}, 16'h00F0);
		chk("pc carry", pc, 16'h1300);
		$display("test index and pc done");
	endtask : t_index_pc
	task automatic t_stack;
		step(CISP_OP_PUSH_ACC, 8'hA5);
		step(CISP_OP_PUSH_STAT, 8'hC3);
		chk("push acc", {we, re, maddr[13:0], wdata, sp}, {2'b10, 14'h00FF, 8'hA5, 8'hFE});
		step(CISP_OP_NONE, 8'h00);
		chk("push stat", {we, maddr[14:0], wdata, sp}, {1'b1, 15'h00FE, 8'h3C, 8'hFD});
		step(CISP_OP_PULL_STAT, 8'h00);
		step(CISP_OP_NONE, 8'h00);
		chk("pull rd", {we, re, busy, maddr[12:0], sp}, {3'b011, 13'h00FE, 8'hFE});
		step(CISP_OP_NONE, 8'h00);
		chk("pull stat", {acc_ld, stat_ld, pdata}, {1'b0, 1'b1, 8'h3C});
		step(CISP_OP_PULL_ACC, 8'h00);
		step(CISP_OP_PULL_STAT, 8'h00);
		chk("pull2 rd", {re, busy, maddr[13:0]}, {2'b11, 14'h00FF});
		step(CISP_OP_NONE, 8'h00);
		chk("pull acc", {acc_ld, stat_ld, pdata, sp}, {1'b1, 1'b0, 8'hA5, 8'hFF});
		step(CISP_OP_NONE, 8'h00);
		chk("refused", {7'h00, re, sp}, 16'h00FF);
		$display("test stack done");
	endtask : t_stack
	task automatic t_page;
		@(posedge clk) {sfr_we, sfr_addr, sfr_wdata} <= {1'b1, 16'h003A, 8'h04};
		@(posedge clk) sfr_addr <= 16'h003B;
		#1 chk("mode miss", {8'h00, mode}, 16'h0000);
		@(posedge clk) {sfr_we, sp_load, sp_data} <= {1'b0, 1'b1, 8'h00};
		@(posedge clk) sp_load <= 1'b0;
		#1 chk("mode", {8'h00, mode}, 16'h0004);
		step(CISP_OP_PUSH_ACC, 8'h77);
		step(CISP_OP_NONE, 8'h00);
		chk("page1 push", {we, maddr, sp}, {1'b1, 16'h0100, 8'hFF});
		step(CISP_OP_PULL_ACC, 8'h00);
		step(CISP_OP_NONE, 8'h00);
		chk("page1 pull", {re, maddr, sp}, {1'b1, 16'h0100, 8'h00});
		step(CISP_OP_NONE, 8'h00);
		chk("page1 data", {acc_ld, pdata}, {1'b1, 8'h77});
		$display("test stack page done");
	endtask : t_page
	// A reset in mid-run must bring back the reset values of Y, pointer, counter, mode and strobes, not only the power-up ones.
	task automatic t_midreset;
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk) #1;
		t_reset();
		$display("test mid-run reset done");
	endtask : t_midreset
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk) #1;
		t_reset();
		t_index_pc();
		t_stack();
		t_page();
		t_midreset();
		complete_run();
	end
	initial begin
		#(50 * 2000);
		n_errors++;
		complete_run();
	end
endmodule : cisp_regs_tb
